// file: verilog/arith_order_params.svh
`ifndef ARITH_ORDER_PARAMS_SVH
`define ARITH_ORDER_PARAMS_SVH

// apb byte offsets
`define ORDER_ADDR 8'h00
`define CMD_ADDR 8'h04
`define STATUS_ADDR 8'h08

// command register bits (write one to act)
`define CMD_LOAD_LEFT 0
`define CMD_LOAD_RIGHT 1
`define CMD_TO_OPERATE 2
`define CMD_TO_CONTROL 3
`define CMD_ARM_CORR 4

// number register word layout
`define HALF_W 10
`define RIGHT_LSB 0
`define LEFT_LSB 10
`define SIGN_BIT 31
`define ORDER_RESET 32'h0000_0000

// decoding register bit positions (bit 9 unused)
`define DEC_ROUNDOFF 0
`define DEC_ADD_SUB 1
`define DEC_ABS 2
`define DEC_CLEAR 3
`define DEC_SECOND_REG 4
`define DEC_MEM_USE 5
`define DEC_RW 6
`define DEC_ADD_MULT 7
`define DEC_SHIFT_DIR 8
`define DEC_RESET 10'h000

// timing
`define CLK_PERIOD_NS 8
`define CARRY_DELAY_NS 13000
`define CARRY_COLLAPSE_NS 9500
`define CARRY_CYCLES ((`CARRY_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// file: verilog/arith_order_pkg.sv
package arith_order_pkg;
  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b00,
    SEQ_CLEAR = 2'b01,
    SEQ_ROUND = 2'b10,
    SEQ_RUN = 2'b11
  } seq_state_type;
endpackage

// file: verilog/carry_delay_timer.sv
`timescale 1ns/1ps
`include "arith_order_params.svh"
module carry_delay_timer #(
  parameter int CYCLES = `CARRY_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic start,
  input wire logic clear,
  output logic done
);
  // the down counter is 16 bits wide
  if (CYCLES < 1 || CYCLES > 65535) $error("carry_delay_timer: bad CYCLES");

  logic [15:0] cnt_r;
  logic [15:0] cnt_nxt;
  logic run_r;
  logic run_nxt;
  logic done_r;
  logic done_nxt;

  always_comb begin
    cnt_nxt = cnt_r;
    run_nxt = run_r;
    done_nxt = done_r;
    if (clear) begin
      run_nxt = 1'b0;
      done_nxt = 1'b0;
    end else if (start) begin
      cnt_nxt = 16'(CYCLES - 1);
      run_nxt = 1'b1;
      done_nxt = 1'b0;
    end else if (run_r) begin
      if (cnt_r == 16'h0000) begin
        run_nxt = 1'b0;
        done_nxt = 1'b1;
      end else begin
        cnt_nxt = cnt_r - 16'h0001;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= 16'h0000;
      run_r <= 1'b0;
      done_r <= 1'b0;
    end else if (clk_en) begin
      cnt_r <= cnt_nxt;
      run_r <= run_nxt;
      done_r <= done_nxt;
    end
  end

  assign done = done_r;
endmodule

// file: verilog/order_decode_reg.sv
`timescale 1ns/1ps
`include "arith_order_params.svh"
module order_decode_reg #(
  parameter int WIDTH = `HALF_W
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic load,
  input wire logic [WIDTH-1:0] half,
  input wire logic [WIDTH-1:0] clr_mask,
  output logic [WIDTH-1:0] dec,
  output logic dir_safety
);
  // bit positions of the flags are fixed, so only one width fits
  if (WIDTH != `HALF_W) $error("order_decode_reg: WIDTH must match order half");

  logic [WIDTH-1:0] dec_r;
  logic [WIDTH-1:0] dec_nxt;
  logic safety_r;
  logic safety_nxt;
  logic copy_r;
  logic copy_nxt;

  always_comb begin
    safety_nxt = load ? half[`DEC_SHIFT_DIR] : safety_r;
    copy_nxt = load;
    for (int i = 0; i < WIDTH; i++) begin
      if (i == `DEC_SHIFT_DIR) begin
        // direction bit only ever follows its safety flag
        dec_nxt[i] = copy_r ? safety_r : dec_r[i];
      end else if (load) begin
        dec_nxt[i] = half[i];
      end else begin
        dec_nxt[i] = clr_mask[i] ? 1'b0 : dec_r[i];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dec_r <= WIDTH'(`DEC_RESET);
      safety_r <= 1'b0;
      copy_r <= 1'b0;
    end else if (clk_en) begin
      dec_r <= dec_nxt;
      safety_r <= safety_nxt;
      copy_r <= copy_nxt;
    end
  end

  assign dec = dec_r;
  assign dir_safety = safety_r;
endmodule

// file: verilog/arith_order_decode_control.sv
// The APB register port and the register addresses were left to the implementer.
`timescale 1ns/1ps
`include "arith_order_params.svh"
module arith_order_decode_control
  import arith_order_pkg::*;
#(
  parameter int CARRY_CYCLES = `CARRY_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic first_clear_phase,
  input wire logic second_clear_phase,
  input wire logic gate_phase_pulse,
  input wire logic end_enable_driver,
  input wire logic corr_sub_done,
  input wire logic slave_clear_req,
  input wire logic acc_sign,
  output logic end_pass_gate,
  output logic false_control_flag,
  output logic end_flag,
  output logic counter_reset_flag,
  output logic second_clear_enable,
  output logic adder_gate_enable,
  output logic gate_phase_enable,
  output logic master_clear_pulse,
  output logic slave_clear_pulse,
  output logic roundoff_insert,
  output logic arith_go,
  output logic complement_sub,
  output logic mem_read,
  output logic mem_write,
  output logic addr_to_order_counter,
  output logic addr_to_shift_counter,
  output logic shift_left,
  output logic shift_right,
  output logic mult_order
);
  // a wait shorter than the collapse time would let unsettled sums through
  if (`CARRY_DELAY_NS <= `CARRY_COLLAPSE_NS) $error("carry delay below collapse");
  if (CARRY_CYCLES < 1 || CARRY_CYCLES > 65535) $error("CARRY_CYCLES out of range");

  // apb slave: zero wait, pready rises in the access phase
  logic pready_r;
  logic pready_nxt;
  logic pslverr_r;
  logic pslverr_nxt;
  logic [31:0] prdata_r;
  logic [31:0] prdata_nxt;
  logic [31:0] order_r;
  logic [31:0] order_nxt;
  logic setup;
  logic wr_acc;
  logic [4:0] cmd;
  logic [31:0] status;

  assign setup = psel && !penable;
  assign wr_acc = psel && penable && pready_r && pwrite;
  assign cmd = (wr_acc && paddr == `CMD_ADDR) ? pwdata[4:0] : 5'h00;

  // control sequence state
  logic operate_r;
  logic operate_nxt;
  logic mcf_r;
  logic mcf_nxt;
  logic fcf_r;
  logic fcf_nxt;
  logic end_r;
  logic end_nxt;
  logic crf_r;
  logic crf_nxt;
  logic eed_r;
  logic dreq_r;
  logic dreq_nxt;
  logic gsl_r;
  logic gsl_nxt;
  seq_state_type seq_r;
  seq_state_type seq_nxt;

  // decoding register
  logic [`HALF_W-1:0] dec;
  logic [`HALF_W-1:0] clr_mask;
  logic dir_safety;
  logic dec_load;
  logic [`HALF_W-1:0] half_sel;

  // orders enter only while the control sequence runs
  assign dec_load = !operate_r && (cmd[`CMD_LOAD_LEFT] || cmd[`CMD_LOAD_RIGHT]);
  assign half_sel = cmd[`CMD_LOAD_LEFT] ? order_r[`LEFT_LSB +: `HALF_W]
                                        : order_r[`RIGHT_LSB +: `HALF_W];

  order_decode_reg #(
    .WIDTH(`HALF_W)
  ) u_dec (
    .pclk(pclk),
    .presetn(presetn),
    .clk_en(clk_en),
    .load(dec_load),
    .half(half_sel),
    .clr_mask(clr_mask),
    .dec(dec),
    .dir_safety(dir_safety)
  );

  logic divide;
  logic delay_start;
  logic delay_done;
  logic delay_done_gate;

  assign divide = dec[`DEC_ADD_MULT] && dec[`DEC_ABS] && operate_r;

  carry_delay_timer #(
    .CYCLES(CARRY_CYCLES)
  ) u_delay (
    .pclk(pclk),
    .presetn(presetn),
    .clk_en(clk_en),
    .start(delay_start && (!dreq_r || gate_phase_pulse)),
    .clear(gate_phase_pulse && !delay_start),
    .done(delay_done)
  );

  // apb next state
  always_comb begin
    pready_nxt = setup;
    pslverr_nxt = 1'b0;
    prdata_nxt = prdata_r;
    order_nxt = order_r;
    if (setup) begin
      prdata_nxt = 32'h0000_0000;
      case (paddr)
        `ORDER_ADDR: prdata_nxt = order_r;
        `CMD_ADDR: prdata_nxt = 32'h0000_0000;
        `STATUS_ADDR: prdata_nxt = status;
        default: pslverr_nxt = 1'b1;
      endcase
    end
    if (wr_acc && paddr == `ORDER_ADDR) begin
      order_nxt = pwdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
      order_r <= `ORDER_RESET;
    end else if (clk_en) begin
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
      prdata_r <= prdata_nxt;
      order_r <= order_nxt;
    end
  end

  // end-of-operation and multiplier-correction flags
  always_comb begin
    operate_nxt = operate_r;
    if (cmd[`CMD_TO_CONTROL]) begin
      operate_nxt = 1'b0;
    end else if (cmd[`CMD_TO_OPERATE]) begin
      operate_nxt = 1'b1;
    end
    mcf_nxt = mcf_r;
    if (corr_sub_done) begin
      mcf_nxt = 1'b1;
    end else if (cmd[`CMD_ARM_CORR]) begin
      mcf_nxt = 1'b0;
    end
    fcf_nxt = fcf_r;
    end_nxt = end_r;
    crf_nxt = crf_r;
    if (end_enable_driver && !eed_r) begin
      end_nxt = 1'b0;
      if (!mcf_r) begin
        fcf_nxt = 1'b1;
      end
    end else if (fcf_r && !end_r) begin
      // the false turnover acts like a control turnover on both flags
      end_nxt = 1'b1;
      crf_nxt = 1'b1;
    end else if (fcf_r && end_r && crf_r) begin
      fcf_nxt = 1'b0;
    end
    if (cmd[`CMD_TO_CONTROL]) begin
      end_nxt = 1'b1;
      crf_nxt = 1'b1;
    end else if (cmd[`CMD_TO_OPERATE]) begin
      crf_nxt = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      operate_r <= 1'b0;
      mcf_r <= 1'b1;
      fcf_r <= 1'b0;
      end_r <= 1'b1;
      crf_r <= 1'b1;
      eed_r <= 1'b0;
    end else if (clk_en) begin
      operate_r <= operate_nxt;
      mcf_r <= mcf_nxt;
      fcf_r <= fcf_nxt;
      end_r <= end_nxt;
      crf_r <= crf_nxt;
      eed_r <= end_enable_driver;
    end
  end

  // carry delay selector and gate-select latch
  assign delay_start = (first_clear_phase && !divide)
                    || (divide && (first_clear_phase || second_clear_phase));
  // an expiry with neither clear phase still up enables nothing
  assign delay_done_gate = delay_done && dreq_r
                        && (first_clear_phase || second_clear_phase);

  always_comb begin
    dreq_nxt = dreq_r;
    if (gate_phase_pulse) begin
      dreq_nxt = 1'b0;
    end
    // a trigger in the clearing cycle still wins
    if (delay_start) begin
      dreq_nxt = 1'b1;
    end
    gsl_nxt = gsl_r;
    if (first_clear_phase) begin
      gsl_nxt = 1'b1;
    end else if (second_clear_phase) begin
      gsl_nxt = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dreq_r <= 1'b0;
      gsl_r <= 1'b0;
    end else if (clk_en) begin
      dreq_r <= dreq_nxt;
      gsl_r <= gsl_nxt;
    end
  end

  // clear and roundoff sequencing before arithmetic
  logic mclr_nxt;
  logic rins_nxt;

  always_comb begin
    seq_nxt = seq_r;
    mclr_nxt = 1'b0;
    rins_nxt = 1'b0;
    clr_mask = '0;
    case (seq_r)
      SEQ_IDLE: begin
        if (operate_r) begin
          if (dec[`DEC_CLEAR]) begin
            mclr_nxt = 1'b1;
            seq_nxt = SEQ_CLEAR;
          end else if (!dec[`DEC_ROUNDOFF]) begin
            seq_nxt = SEQ_RUN;
          end
          // roundoff without clear stays here for good
        end
      end
      SEQ_CLEAR: begin
        clr_mask[`DEC_CLEAR] = 1'b1;
        clr_mask[`DEC_SECOND_REG] = 1'b1;
        seq_nxt = dec[`DEC_ROUNDOFF] ? SEQ_ROUND : SEQ_RUN;
      end
      SEQ_ROUND: begin
        rins_nxt = 1'b1;
        clr_mask[`DEC_ROUNDOFF] = 1'b1;
        seq_nxt = SEQ_RUN;
      end
      SEQ_RUN: begin
        if (!operate_r) begin
          seq_nxt = SEQ_IDLE;
        end
      end
      default: seq_nxt = SEQ_IDLE;
    endcase
    if (!operate_r) begin
      seq_nxt = SEQ_IDLE;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seq_r <= SEQ_IDLE;
    end else if (clk_en) begin
      seq_r <= seq_nxt;
    end
  end

  // decoded outputs, all registered
  logic [2:0] cond_bits;
  logic go_now;
  logic [18:0] out_nxt;
  logic [18:0] out_r;

  assign go_now = operate_r && !dec[`DEC_CLEAR] && !dec[`DEC_ROUNDOFF]
               && (seq_r == SEQ_RUN);
  assign cond_bits = {dec[`DEC_MEM_USE], dec[`DEC_RW], dec[`DEC_SECOND_REG]};

  always_comb begin
    out_nxt = '0;
    out_nxt[0] = end_enable_driver && mcf_r;
    out_nxt[1] = fcf_nxt;
    out_nxt[2] = end_nxt;
    out_nxt[3] = crf_nxt;
    out_nxt[4] = delay_done_gate
              || (second_clear_phase && !divide);
    out_nxt[5] = gsl_nxt;
    out_nxt[6] = !gsl_nxt;
    out_nxt[7] = mclr_nxt;
    out_nxt[8] = slave_clear_req && !dec[`DEC_CLEAR];
    out_nxt[9] = rins_nxt;
    out_nxt[10] = go_now;
    // subtract, add abs of negative, subtract abs of positive
    out_nxt[11] = dec[`DEC_ABS] ? (dec[`DEC_ADD_SUB] ^ order_r[`SIGN_BIT])
                               : dec[`DEC_ADD_SUB];
    if (operate_r) begin
      out_nxt[12] = dec[`DEC_MEM_USE] && dec[`DEC_RW];
      out_nxt[13] = dec[`DEC_MEM_USE] && !dec[`DEC_RW];
      // conditional transfer only jumps on a non-negative accumulator
      out_nxt[14] = (cond_bits == 3'b010)
                 || (cond_bits == 3'b011 && !acc_sign);
      out_nxt[15] = !dec[`DEC_MEM_USE] && !dec[`DEC_RW];
      out_nxt[16] = !dec[`DEC_SHIFT_DIR];
      out_nxt[17] = dec[`DEC_SHIFT_DIR];
      out_nxt[18] = dec[`DEC_ADD_MULT] && !dec[`DEC_ABS];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_r <= 19'h0000c;
    end else if (clk_en) begin
      out_r <= out_nxt;
    end
  end

  assign status = {11'h000, dir_safety, seq_r, gsl_r, dreq_r, crf_r, end_r,
                   fcf_r, mcf_r, operate_r, 1'b0, dec};

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign end_pass_gate = out_r[0];
  assign false_control_flag = out_r[1];
  assign end_flag = out_r[2];
  assign counter_reset_flag = out_r[3];
  assign second_clear_enable = out_r[4];
  assign adder_gate_enable = out_r[5];
  assign gate_phase_enable = out_r[6];
  assign master_clear_pulse = out_r[7];
  assign slave_clear_pulse = out_r[8];
  assign roundoff_insert = out_r[9];
  assign arith_go = out_r[10];
  assign complement_sub = out_r[11];
  assign mem_read = out_r[12];
  assign mem_write = out_r[13];
  assign addr_to_order_counter = out_r[14];
  assign addr_to_shift_counter = out_r[15];
  assign shift_left = out_r[16];
  assign shift_right = out_r[17];
  assign mult_order = out_r[18];
endmodule

// file: bench/order_ctrl_assertions.sv
`timescale 1ns/1ps
module order_ctrl_checker #(
  parameter int CARRY_CYCLES = 1625
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic first_clear_phase,
  input wire logic second_clear_phase,
  input wire logic end_enable_driver,
  input wire logic slave_clear_req,
  input wire logic end_pass_gate,
  input wire logic false_control_flag,
  input wire logic end_flag,
  input wire logic counter_reset_flag,
  input wire logic second_clear_enable,
  input wire logic adder_gate_enable,
  input wire logic gate_phase_enable,
  input wire logic master_clear_pulse,
  input wire logic slave_clear_pulse,
  input wire logic roundoff_insert,
  input wire logic arith_go,
  input wire logic mem_read,
  input wire logic mem_write,
  input wire logic addr_to_order_counter,
  input wire logic addr_to_shift_counter
);
  localparam int LATE = CARRY_CYCLES + 6;
  logic [15:0] cnt_r;
  logic [15:0] cnt_nxt;
  // saturating, so a stuck clear phase cannot wrap back into the legal window
  always_comb begin
    cnt_nxt = 16'h0000;
    if (first_clear_phase && !second_clear_phase) begin
      cnt_nxt = (cnt_r == 16'hffff) ? cnt_r : cnt_r + 16'h0001;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= 16'h0000;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence turnover_s;
    end_flag && counter_reset_flag;
  endsequence
  sequence first_only_s;
    $rose(first_clear_phase) && !second_clear_phase;
  endsequence
  apb_answer_a: assert property (pready |-> $past(psel && !penable))
    else $error("pready without setup");
  apb_error_a: assert property (pslverr |-> pready)
    else $error("pslverr outside access");
  end_blocked_a: assert property ($rose(false_control_flag) |-> !end_pass_gate)
    else $error("end passed during correction");
  turnover_a: assert property ($rose(false_control_flag) |-> ##[0:2] turnover_s)
    else $error("false turnover left flags low");
  end_pass_a: assert property (end_pass_gate |-> $past(end_enable_driver))
    else $error("end pass without end enable");
  delay_min_a: assert property ($rose(second_clear_enable) && !second_clear_phase |->
    cnt_r >= CARRY_CYCLES) else $error("second clear before carry settled");
  delay_max_a: assert property (first_only_s |-> ##[1:LATE] second_clear_enable)
    else $error("second clear never enabled");
  latch_set_a: assert property (first_only_s |-> ##[1:3] adder_gate_enable)
    else $error("gate latch not set");
  gate_excl_a: assert property ($past(presetn) |-> adder_gate_enable != gate_phase_enable)
    else $error("gate enables not exclusive");
  master_clear_a: assert property (master_clear_pulse |->
    !slave_clear_pulse && !arith_go ##1 !master_clear_pulse) else $error("bad master clear");
  round_pulse_a: assert property (roundoff_insert |-> !arith_go ##1 !roundoff_insert)
    else $error("bad roundoff pulse");
  slave_cause_a: assert property (slave_clear_pulse |-> $past(slave_clear_req))
    else $error("slave clear without request");
  mem_onehot_a: assert property ($onehot0({mem_read, mem_write,
    addr_to_order_counter, addr_to_shift_counter})) else $error("memory decode not one hot");
endmodule
bind arith_order_decode_control order_ctrl_checker #(.CARRY_CYCLES(CARRY_CYCLES)) chk (.*);

// file: bench/seq_partner.sv
`timescale 1ns/1ps
module seq_partner (
  input wire logic pclk,
  input wire logic second_clear_enable,
  output logic first_clear_phase,
  output logic second_clear_phase,
  output logic gate_phase_pulse,
  output logic end_enable_driver,
  output logic corr_sub_done
);
  initial begin
    first_clear_phase = 1'b0;
    second_clear_phase = 1'b0;
    gate_phase_pulse = 1'b0;
    end_enable_driver = 1'b0;
    corr_sub_done = 1'b0;
  end
  // holds the clear on until released; n is the wait in cycles
  task automatic clear_step(input logic sec, output int n);
    n = 0;
    @(posedge pclk);
    first_clear_phase <= ~sec;
    second_clear_phase <= sec;
    do begin
      @(posedge pclk);
      n++;
    end while (second_clear_enable !== 1'b1 && n < 200);
    first_clear_phase <= 1'b0;
    second_clear_phase <= 1'b0;
    @(posedge pclk);
    gate_phase_pulse <= 1'b1;
    @(posedge pclk);
    gate_phase_pulse <= 1'b0;
  endtask
  task automatic end_step();
    @(posedge pclk);
    end_enable_driver <= 1'b1;
    repeat (3) @(posedge pclk);
    end_enable_driver <= 1'b0;
    repeat (3) @(posedge pclk);
  endtask
  task automatic corr_step();
    @(posedge pclk);
    corr_sub_done <= 1'b1;
    @(posedge pclk);
    corr_sub_done <= 1'b0;
  endtask
endmodule

// file: bench/tb_arith_order_decode_control.sv
`timescale 1ns/1ps
`include "arith_order_params.svh"
module tb_arith_order_decode_control;
  // short timer keeps the run small; delay windows below follow from it
  localparam int CARRY_CYCLES = 12;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic clk_en = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, slave_clear_req = 1'b0, acc_sign = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, st, q;
  logic pready, pslverr, e, first_clear_phase, second_clear_phase, gate_phase_pulse;
  logic end_enable_driver, corr_sub_done, end_pass_gate, false_control_flag, end_flag;
  logic counter_reset_flag, second_clear_enable, adder_gate_enable, gate_phase_enable;
  logic master_clear_pulse, slave_clear_pulse, roundoff_insert, arith_go, complement_sub;
  logic mem_read, mem_write, addr_to_order_counter, addr_to_shift_counter;
  logic shift_left, shift_right, mult_order;
  int bad_count = 0, checks_done = 0, mc_cnt = 0, ri_cnt = 0, ep_cnt = 0, fc_cnt = 0, n, m, r;
  always #4 pclk = ~pclk;
  arith_order_decode_control #(.CARRY_CYCLES(CARRY_CYCLES)) dut (.*);
  seq_partner p (.*);
  always @(posedge pclk) begin
    if (master_clear_pulse === 1'b1) mc_cnt++;
    if (roundoff_insert === 1'b1) ri_cnt++;
    if (end_pass_gate === 1'b1) ep_cnt++;
    if (false_control_flag === 1'b1) fc_cnt++;
  end
  task automatic check_val(input string w, input logic [31:0] x, input logic [31:0] g);
    checks_done++;
    if (g !== x) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", w, x, g);
    end
  endtask
  task automatic check_bit(input string w, input logic x, input logic g);
    check_val(w, {31'h0, x}, {31'h0, g});
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rq, output logic re);
    int k;
    k = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1);
    rq = prdata;
    re = pslverr;
    check_val("apb wait", 32'h1, 32'(k));
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, q, e);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    apb(1'b0, a, 32'h0, d, e);
  endtask
  task automatic load_order(input logic [9:0] o, input logic s, input logic l);
    wr(`CMD_ADDR, 32'h8);
    wr(`ORDER_ADDR, l ? {s, 11'h0, o, 10'h0} : {s, 21'h0, o});
    wr(`CMD_ADDR, l ? 32'h1 : 32'h2);
    rd(`STATUS_ADDR, st);
    check_val("order", {22'h0, o}, {22'h0, st[9:0]});
    check_bit("dir copy", o[8], st[20]);
    check_bit("control", 1'b0, st[11]);
  endtask
  task automatic go();
    wr(`CMD_ADDR, 32'h4);
    repeat (4) @(posedge pclk);
  endtask
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    check_val("reset flags", 32'h3, {29'h0, false_control_flag, end_flag, counter_reset_flag});
    apb(1'b0, 8'h0c, 32'h0, q, e);
    check_bit("unmapped err", 1'b1, e);
    check_val("unmapped data", 32'h0, q);
    $display("test reset finished");
    for (int i = 0; i < 4; i++) begin
      load_order({1'b0, i[0], i[1], i[0], i[1], 5'h0}, 1'b0, i[0]);
      check_val("ctrl mem", 32'h0, {28'h0, mem_read, mem_write,
                addr_to_order_counter, addr_to_shift_counter});
      go();
      check_val("mem", 32'h1 << i, {28'h0, mem_read, mem_write,
                addr_to_order_counter, addr_to_shift_counter});
      check_val("shift", {30'h0, i[0], ~i[0]}, {30'h0, shift_right, shift_left});
      check_bit("mult", i[1], mult_order);
    end
    for (int s = 0; s < 2; s++) begin
      acc_sign <= s[0];
      load_order(10'h050, 1'b0, 1'b0);
      go();
      check_bit("cond jump", ~s[0], addr_to_order_counter);
    end
    // with the enable low the new sign must not reach the output
    clk_en <= 1'b0;
    acc_sign <= 1'b0;
    repeat (3) @(posedge pclk);
    check_bit("frozen jump", 1'b0, addr_to_order_counter);
    clk_en <= 1'b1;
    repeat (2) @(posedge pclk);
    check_bit("thawed jump", 1'b1, addr_to_order_counter);
    for (int i = 0; i < 8; i++) begin
      load_order({7'h0, i[1], i[0], 1'b0}, i[2], 1'b0);
      go();
      check_bit("complement", i[1] ? i[0] ^ i[2] : i[0], complement_sub);
    end
    $display("test decode finished");
    load_order(10'h000, 1'b0, 1'b0);
    go();
    fork
      p.clear_step(1'b0, n);
      begin
        repeat (5) @(posedge pclk);
        rd(`STATUS_ADDR, st);
      end
    join
    check_bit("first delay", 1'b1, n >= CARRY_CYCLES && n <= CARRY_CYCLES + 4);
    check_bit("request", 1'b1, st[16]);
    check_bit("adder gate", 1'b1, adder_gate_enable);
    rd(`STATUS_ADDR, st);
    check_bit("request cleared", 1'b0, st[16]);
    p.clear_step(1'b1, n);
    check_bit("no delay", 1'b1, n <= 3);
    check_bit("other gate", 1'b1, gate_phase_enable);
    load_order(10'h084, 1'b0, 1'b0);
    go();
    p.clear_step(1'b1, n);
    check_bit("divide delay", 1'b1, n >= CARRY_CYCLES);
    $display("test delay finished");
    wr(`CMD_ADDR, 32'h10);
    rd(`STATUS_ADDR, st);
    check_bit("armed", 1'b0, st[12]);
    m = ep_cnt;
    r = fc_cnt;
    p.end_step();
    check_bit("end blocked", 1'b1, ep_cnt == m && fc_cnt > r);
    check_val("turnover", 32'h3, {29'h0, false_control_flag, end_flag, counter_reset_flag});
    p.corr_step();
    rd(`STATUS_ADDR, st);
    check_bit("corr back", 1'b1, st[12]);
    m = ep_cnt;
    r = fc_cnt;
    p.end_step();
    check_bit("end passes", 1'b1, ep_cnt > m && fc_cnt == r);
    $display("test end finished");
    slave_clear_req <= 1'b1;
    // the stalling roundoff-without-clear case runs last, it never completes
    for (int i = 0; i < 3; i++) begin
      logic c, o;
      c = (i != 2);
      o = (i != 1);
      m = mc_cnt;
      r = ri_cnt;
      load_order({2'h0, 1'b1, 3'h0, c, 2'h0, o}, 1'b0, 1'b0);
      go();
      repeat (6) @(posedge pclk);
      rd(`STATUS_ADDR, st);
      check_val("pulses", {30'h0, c, c & o},
                {30'h0, mc_cnt - m == 1, ri_cnt - r == 1});
      check_val("clear bits", {30'h0, 1'b0, o & ~c}, {30'h0, st[3], st[0]});
      check_bit("go", c | ~o, arith_go);
      check_bit("slave clear", 1'b1, slave_clear_pulse);
    end
    $display("test clear finished");
    give_verdict();
  end
  initial begin
    repeat (30000) @(posedge pclk);
    bad_count++;
    give_verdict();
  end
endmodule
